// ==== rtl/rpac_map.svh ====
/*
 Register offsets, field positions, reset values and timing counts of the
 real-time clock. Assumes a 125 MHz system clock and byte addressing on APB.
*/
`ifndef RPAC_MAP_SVH
`define RPAC_MAP_SVH

`define RPAC_OFF_CTRL      12'h000
`define RPAC_OFF_PRESC     12'h004
`define RPAC_OFF_COUNT     12'h008
`define RPAC_OFF_ALARM     12'h00C
`define RPAC_OFF_NTICK     12'h010
`define RPAC_OFF_WDLY      12'h014
`define RPAC_OFF_STAT      12'h018
`define RPAC_OFF_MASK      12'h01C
`define RPAC_OFF_XSEL      12'h020
`define RPAC_OFF_LONG_LO   12'h024
`define RPAC_OFF_LONG_HI   12'h028
`define RPAC_OFF_SRC       12'h02C

`define RPAC_CTRL_EN       0
`define RPAC_CTRL_OSCOFF   1
`define RPAC_CTRL_POWERDOWN_WAKEUP_CONFIG   2
`define RPAC_CTRL_PDRUN    3
`define RPAC_CTRL_NTHEN    4
`define RPAC_CTRL_TICKEN   5

`define RPAC_EV_TICK       0
`define RPAC_EV_ALARM      1
`define RPAC_EV_NTH        2
`define RPAC_EV_WAKE       3

`define RPAC_RST_CTRL      6'h01
`define RPAC_RST_PRESC     20'hFFFFF
`define RPAC_RST_NTICK     16'h0001

`define RPAC_CLK_NS        8
`define RPAC_DETECT_NS     125000
`define RPAC_DETECT_CYC    (`RPAC_DETECT_NS / `RPAC_CLK_NS)
`define RPAC_DETECT_EDGES  8'h04

`endif

// ==== rtl/rpac_pkg.sv ====
/*
 Types shared by the real-time clock modules.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package rpac_pkg;
    typedef enum logic {RPAC_DET_WAIT, RPAC_DET_DONE} rpac_det_t;
    typedef logic [31:0] rpac_word_t;
    typedef logic [57:0] rpac_long_t;
endpackage

// ==== rtl/rpac_prescaler.sv ====
/*
 Fixed divide-by-64 stage followed by the reloadable 20-bit divider.
 Assumes run, use_lp and lp_edge are synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module rpac_prescaler #(
    parameter int DIV_W = 20,
    parameter int PRE_W = 6
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             arst_n,
    // Control
    input  wire logic             run,
    input  wire logic             use_lp,
    input  wire logic             lp_edge,
    input  wire logic             restart,
    input  wire logic [DIV_W-1:0] reload,
    // State
    output logic                  tick,
    output logic [PRE_W-1:0]      pre,
    output logic [DIV_W-1:0]      div
);
    logic step;

    // Low-power source bypasses the fixed stage
    assign step = run & (use_lp ? lp_edge : (&pre));

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pre <= '0;
        end else if (restart) begin
            pre <= '0;
        end else if (run && !use_lp) begin
            pre <= pre + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div  <= '0;
            tick <= 1'b0;
        end else begin
            tick <= step && (div == '0);
            if (restart) begin
                div <= reload;
            end else if (step) begin
                div <= (div == '0) ? reload : div - 1'b1;
            end
        end
    end

    a_tick_reload: assert property (@(posedge clk) disable iff (!arst_n)
        tick |-> div == $past(reload))
        else $error("divider not reloaded on tick");
    a_pre_stage: assert property (@(posedge clk) disable iff (!arst_n)
        (step && !use_lp) |-> pre == {PRE_W{1'b1}})
        else $error("step outside fixed stage wrap");
    a_tick_single: assert property (@(posedge clk) disable iff (!arst_n)
        (tick && !use_lp) |=> !tick [*8])
        else $error("tick longer than one cycle");
endmodule
`default_nettype wire

// ==== rtl/rpac_counter.sv ====
/*
 32-bit time counter with alarm compare.
 Assumes tick is a one-cycle pulse synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module rpac_counter (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // Control
    input  wire logic        tick,
    input  wire logic        wr_en,
    input  wire logic [31:0] wr_data,
    input  wire logic [31:0] alarm,
    // State
    output logic      [31:0] count,
    output logic             alarm_hit
);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count <= '0;
        end else if (wr_en) begin
            count <= wr_data;
        end else if (tick) begin
            count <= count + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            alarm_hit <= 1'b0;
        end else begin
            alarm_hit <= tick && !wr_en && (32'(count + 1'b1) == alarm);
        end
    end

    a_count_step: assert property (@(posedge clk) disable iff (!arst_n)
        (tick && !wr_en) |=> count == 32'($past(count) + 1'b1))
        else $error("counter did not advance");
    a_count_hold: assert property (@(posedge clk) disable iff (!arst_n)
        (!tick && !wr_en) |=> $stable(count))
        else $error("counter moved without tick");
    a_alarm_equal: assert property (@(posedge clk) disable iff (!arst_n)
        alarm_hit |-> count == $past(alarm))
        else $error("alarm without match");
endmodule
`default_nettype wire

// ==== rtl/rpac_top.sv ====
/*
 Real-time clock: APB register file, oscillator source detection,
 power-down oscillator control, n-tick and wake timers, interrupts.
 Assumes all inputs synchronous to clk; the low-power oscillator input
 is sampled as a level and its rising edges counted.
*/
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rpac_map.svh"
module rpac_top #(
    parameter int DETECT_CYCLES = `RPAC_DETECT_CYC,
    parameter int NTICK_W       = 16
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // APB slave
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Oscillators and power
    input  wire logic        low_power_oscillator_input,
    input  wire logic        powerdown_active,
    output logic             main_osc_en,
    output logic             lp_osc_en,
    // Requests
    output logic             tick_interrupt_request,
    output logic             alarm_interrupt_request,
    output logic             nth_tick_request,
    output logic             external_interrupt_request,
    output logic             wakeup_request,
    output logic             irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    localparam logic [3:0] IDX_NONE = 4'hF;

    function automatic logic [3:0] rpac_idx(input logic [11:0] a);
        case (a)
            `RPAC_OFF_CTRL:    rpac_idx = 4'h0;
            `RPAC_OFF_PRESC:   rpac_idx = 4'h1;
            `RPAC_OFF_COUNT:   rpac_idx = 4'h2;
            `RPAC_OFF_ALARM:   rpac_idx = 4'h3;
            `RPAC_OFF_NTICK:   rpac_idx = 4'h4;
            `RPAC_OFF_WDLY:    rpac_idx = 4'h5;
            `RPAC_OFF_STAT:    rpac_idx = 4'h6;
            `RPAC_OFF_MASK:    rpac_idx = 4'h7;
            `RPAC_OFF_XSEL:    rpac_idx = 4'h8;
            `RPAC_OFF_LONG_LO: rpac_idx = 4'h9;
            `RPAC_OFF_LONG_HI: rpac_idx = 4'hA;
            `RPAC_OFF_SRC:     rpac_idx = 4'hB;
            default:           rpac_idx = IDX_NONE;
        endcase
    endfunction

    logic [5:0]          ctrl;
    logic [19:0]         presc;
    logic [31:0]         alarm;
    logic [NTICK_W-1:0]  ntick_n;
    logic [NTICK_W-1:0]  ntick_cnt;
    logic [NTICK_W-1:0]  wake_dly;
    logic [NTICK_W-1:0]  wake_cnt;
    logic [3:0]          stat;
    logic [3:0]          mask;
    logic [2:0]          xsel;
    logic [25:0]         long_hi_snap;
    logic [3:0]          idx;
    logic                setup;
    logic                wr;
    logic                rd_lo;
    logic                lp_q;
    logic                lp_edge;
    logic                lp_detected;
    logic [31:0]         det_cnt;
    logic [7:0]          edge_cnt;
    rpac_pkg::rpac_det_t det_state;
    logic                run;
    logic                tick;
    logic                alarm_hit;
    logic                nth_pulse;
    logic                wake_pulse;
    logic [3:0]          ev;
    logic [5:0]          pre;
    logic [19:0]         div;
    logic [19:0]         reload_val;
    logic [31:0]         count;
    rpac_pkg::rpac_long_t long_t;

    assign idx     = rpac_idx(paddr);
    assign setup   = psel && !penable;
    assign wr      = psel && penable && pwrite && (idx != IDX_NONE);
    assign rd_lo   = setup && !pwrite && (idx == 4'h9);
    assign pready  = 1'b1;
    assign pslverr = psel && penable && (idx == IDX_NONE);
    assign long_t  = {count, div, pre};

    // Reload write restarts the divider, so it must load the new value
    assign reload_val = (wr && idx == 4'h1) ? pwdata[19:0] : presc;

    // Control and setup registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl     <= `RPAC_RST_CTRL;
            presc    <= `RPAC_RST_PRESC;
            alarm    <= '0;
            ntick_n  <= NTICK_W'(`RPAC_RST_NTICK);
            wake_dly <= '0;
            mask     <= '0;
            xsel     <= '0;
        end else if (wr) begin
            case (idx)
                4'h0:    ctrl     <= pwdata[5:0];
                4'h1:    presc    <= pwdata[19:0];
                4'h3:    alarm    <= pwdata;
                4'h4:    ntick_n  <= pwdata[NTICK_W-1:0];
                4'h5:    wake_dly <= pwdata[NTICK_W-1:0];
                4'h7:    mask     <= pwdata[3:0];
                4'h8:    xsel     <= pwdata[2:0];
                default: ctrl     <= ctrl;
            endcase
        end
    end

    // Read data captured in setup, steady through access
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= '0;
        end else if (setup && !pwrite) begin
            case (idx)
                4'h0:    prdata <= {26'h0, ctrl};
                4'h1:    prdata <= {12'h0, presc};
                4'h2:    prdata <= count;
                4'h3:    prdata <= alarm;
                4'h4:    prdata <= 32'(ntick_n);
                4'h5:    prdata <= 32'(wake_dly);
                4'h6:    prdata <= {28'h0, stat};
                4'h7:    prdata <= {28'h0, mask};
                4'h8:    prdata <= {29'h0, xsel};
                4'h9:    prdata <= long_t[31:0];
                4'hA:    prdata <= {6'h0, long_hi_snap};
                4'hB:    prdata <= {31'h0, lp_detected};
                default: prdata <= '0;
            endcase
        end
    end

    // High half frozen by low read so the pair does not tear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            long_hi_snap <= '0;
        end else if (rd_lo) begin
            long_hi_snap <= long_t[57:32];
        end
    end

    // Low-power oscillator edge, input already synchronous
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lp_q <= 1'b0;
        end else begin
            lp_q <= low_power_oscillator_input;
        end
    end
    assign lp_edge = low_power_oscillator_input && !lp_q;

    // Source decided once after reset, then frozen
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            det_state   <= rpac_pkg::RPAC_DET_WAIT;
            det_cnt     <= '0;
            edge_cnt    <= '0;
            lp_detected <= 1'b0;
        end else begin
            case (det_state)
                rpac_pkg::RPAC_DET_WAIT: begin
                    det_cnt <= det_cnt + 1'b1;
                    if (lp_edge && edge_cnt != 8'hFF) begin
                        edge_cnt <= edge_cnt + 1'b1;
                    end
                    if (det_cnt == 32'(DETECT_CYCLES - 1)) begin
                        lp_detected <= (edge_cnt >= `RPAC_DETECT_EDGES);
                        det_state   <= rpac_pkg::RPAC_DET_DONE;
                    end
                end
                rpac_pkg::RPAC_DET_DONE: begin
                    det_state <= rpac_pkg::RPAC_DET_DONE;
                end
                default: begin
                    det_state <= rpac_pkg::RPAC_DET_WAIT;
                end
            endcase
        end
    end

    // Keeps counting in power-down only when asked to
    assign run = ctrl[`RPAC_CTRL_EN] && !(powerdown_active && !ctrl[`RPAC_CTRL_PDRUN]);

    rpac_prescaler #(
        .DIV_W (20),
        .PRE_W (6)
    ) u_presc (
        .clk     (clk),
        .arst_n  (arst_n),
        .run     (run),
        .use_lp  (lp_detected),
        .lp_edge (lp_edge),
        .restart (wr && (idx == 4'h1 || idx == 4'h2)),
        .reload  (reload_val),
        .tick    (tick),
        .pre     (pre),
        .div     (div)
    );

    rpac_counter u_count (
        .clk       (clk),
        .arst_n    (arst_n),
        .tick      (tick),
        .wr_en     (wr && idx == 4'h2),
        .wr_data   (pwdata),
        .alarm     (alarm),
        .count     (count),
        .alarm_hit (alarm_hit)
    );

    // n-tick divider; a programmed zero behaves as one
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ntick_cnt <= '0;
            nth_pulse <= 1'b0;
        end else begin
            nth_pulse <= 1'b0;
            if (!ctrl[`RPAC_CTRL_NTHEN]) begin
                ntick_cnt <= '0;
            end else if (tick) begin
                if (ntick_cnt + 1'b1 >= ntick_n) begin
                    ntick_cnt <= '0;
                    nth_pulse <= 1'b1;
                end else begin
                    ntick_cnt <= ntick_cnt + 1'b1;
                end
            end
        end
    end

    // Wake timer counts ticks only while powered down
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wake_cnt   <= '0;
            wake_pulse <= 1'b0;
        end else begin
            wake_pulse <= 1'b0;
            if (!powerdown_active || !ctrl[`RPAC_CTRL_POWERDOWN_WAKEUP_CONFIG]) begin
                wake_cnt <= '0;
            end else if (tick) begin
                wake_cnt <= wake_cnt + 1'b1;
                if (wake_cnt == wake_dly) begin
                    wake_pulse <= 1'b1;
                end
            end
        end
    end

    assign ev = {wake_pulse, nth_pulse, alarm_hit, tick};

    // Sticky status, write one to clear; a new event wins
    for (genvar i = 0; i < 4; i++) begin : g_stat
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                stat[i] <= 1'b0;
            end else if (ev[i]) begin
                stat[i] <= 1'b1;
            end else if (wr && idx == 4'h6 && pwdata[i]) begin
                stat[i] <= 1'b0;
            end
        end
    end
    assign irq = |(stat & mask);

    // Request pulses, one cycle each; external spans two if a selected tick precedes alarm or n-tick, wake if it precedes alarm or wake
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_interrupt_request     <= 1'b0;
            alarm_interrupt_request    <= 1'b0;
            nth_tick_request           <= 1'b0;
            external_interrupt_request <= 1'b0;
            wakeup_request             <= 1'b0;
        end else begin
            tick_interrupt_request     <= tick && ctrl[`RPAC_CTRL_TICKEN];
            alarm_interrupt_request    <= alarm_hit;
            nth_tick_request           <= nth_pulse;
            external_interrupt_request <= |(ev[2:0] & xsel);
            wakeup_request             <= powerdown_active && (wake_pulse || |(ev[1:0] & xsel[1:0]));
        end
    end

    // Oscillator enables for power-down
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            main_osc_en <= 1'b1;
            lp_osc_en   <= 1'b1;
        end else begin
            main_osc_en <= !(powerdown_active && (!ctrl[`RPAC_CTRL_EN] || ctrl[`RPAC_CTRL_OSCOFF]
                             || lp_detected));
            lp_osc_en   <= !(powerdown_active && !ctrl[`RPAC_CTRL_EN]);
        end
    end

    sequence s_stat_clear;
        wr && idx == 4'h6 && pwdata[`RPAC_EV_ALARM];
    endsequence
    sequence s_alarm_event;
        alarm_hit;
    endsequence

    a_alarm_sticky: assert property (
        (s_alarm_event and s_stat_clear) |=> stat[`RPAC_EV_ALARM])
        else $error("alarm lost to clear");
    a_irq_level: assert property (
        (alarm_hit && mask[`RPAC_EV_ALARM] && !(wr && idx == 4'h7)) |=> irq)
        else $error("irq does not follow alarm");
    a_alarm_out: assert property (
        s_alarm_event |=> alarm_interrupt_request ##1 !alarm_interrupt_request)
        else $error("alarm request not one pulse");
    a_main_osc_off: assert property (
        (powerdown_active && ctrl[`RPAC_CTRL_OSCOFF]) |=> !main_osc_en)
        else $error("main oscillator left on");
    a_both_off: assert property (
        (powerdown_active && !ctrl[`RPAC_CTRL_EN]) |=> !main_osc_en && !lp_osc_en)
        else $error("oscillators left on when disabled");
    a_main_kept: assert property (
        (!lp_detected && ctrl[`RPAC_CTRL_EN] && !ctrl[`RPAC_CTRL_OSCOFF]) |=> main_osc_en)
        else $error("main oscillator stopped without cause");
    a_wake_pd: assert property (
        wakeup_request |-> $past(powerdown_active))
        else $error("wake outside power-down");
    a_slverr: assert property (
        (psel && penable && idx != IDX_NONE) |-> !pslverr)
        else $error("error on mapped register");
    a_pd_stop: assert property (
        (powerdown_active && !ctrl[`RPAC_CTRL_PDRUN]) |-> !run)
        else $error("counting in power-down when stopped");
endmodule
`default_nettype wire

// ==== tb/rpac_lp_osc_model.sv ====
/*
 Behavioural 32 kHz low-power oscillator seen by the real-time clock.
 Assumes a sped-up oscillator: one level change every HALF system clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module rpac_lp_osc_model #(
    parameter int HALF = 4
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // Control
    input  wire logic present,
    input  wire logic lp_osc_en,
    // Oscillator
    output logic      osc_out
);
    int cnt;

    // Stopped or absent crystal rests low, as a real one would
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt     <= 0;
            osc_out <= 1'b0;
        end else if (!(present && lp_osc_en)) begin
            cnt     <= 0;
            osc_out <= 1'b0;
        end else if (cnt == HALF - 1) begin
            cnt     <= 0;
            osc_out <= !osc_out;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule
`default_nettype wire

// ==== tb/rtc_prescaler_alarm_counter_tb.sv ====
/*
 Self-checking bench for the real-time clock over APB.
 Assumes the hand-over timing: zero wait states, requests one cycle long.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rpac_map.svh"
module rtc_prescaler_alarm_counter_tb;
    logic        clk, arst_n, psel, penable, pwrite, pd, osc_on;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, err, lp, mosc, losc;
    logic        tick, alarm, nth, ext, wake, irq;
    int          num_errors, checks, cyc, n;

`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
    $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end

    rpac_top #(.DETECT_CYCLES(64)) dut (
        .clk(clk), .arst_n(arst_n), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .low_power_oscillator_input(lp), .powerdown_active(pd),
        .main_osc_en(mosc), .lp_osc_en(losc), .tick_interrupt_request(tick),
        .alarm_interrupt_request(alarm), .nth_tick_request(nth),
        .external_interrupt_request(ext), .wakeup_request(wake), .irq(irq));

    rpac_lp_osc_model osc (.clk(clk), .arst_n(arst_n), .present(osc_on),
        .lp_osc_en(losc), .osc_out(lp));

    initial begin
        clk = 1'b0;
        forever #4 clk = !clk;
    end

    // Hang guard, well above the longest sequence
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            report_and_stop();
        end
    end

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic do_reset(input logic present);
        arst_n <= 1'b0;
        osc_on <= present;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        repeat (80) @(posedge clk);
    endtask

    // Request watched by the gap timer: 0 tick, 1 n-tick, 2 external
    function automatic logic req(input int sel);
        return (sel == 2) ? ext : (sel == 1) ? nth : tick;
    endfunction

    // Clocks from one request to the next; returns on a rising edge
    task automatic tick_gap(input int sel, output int g);
        g = 0;
        do @(negedge clk); while (req(sel) !== 1'b1);
        do begin @(negedge clk); g++; end while (req(sel) !== 1'b1 && g < 3000);
        @(posedge clk);
    endtask

    task automatic report_and_stop();
        $display("Counts: %0d checks, %0d errors", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        {psel, penable, pwrite, pd, osc_on, lp} = '0;
        paddr = '0; pwdata = '0; num_errors = 0; checks = 0; cyc = 0;
        arst_n = 1'b0;
        do_reset(1'b0);
        apb(0, `RPAC_OFF_CTRL, 0);  `CHK(rd, 32'h00000001)
        apb(0, `RPAC_OFF_PRESC, 0); `CHK(rd, 32'h000FFFFF)
        apb(0, `RPAC_OFF_SRC, 0);   `CHK(rd[0], 1'b0)
        apb(0, 12'h0FC, 0);         `CHK(err, 1'b1)
        $display("Reset values done");
        // Period is 64 * (reload + 1) clocks
        for (int p = 0; p < 3; p++) begin
            apb(1, `RPAC_OFF_PRESC, p);
            apb(1, `RPAC_OFF_CTRL, 32'h21);
            tick_gap(0, n); `CHK(n, 64 * (p + 1))
        end
        apb(1, `RPAC_OFF_CTRL, 32'h01);
        apb(1, `RPAC_OFF_PRESC, 0);
        apb(1, `RPAC_OFF_COUNT, 32'h00000010);
        repeat (200) @(posedge clk);
        apb(0, `RPAC_OFF_COUNT, 0); `CHK(rd, 32'h00000013)
        $display("Tick timing done");
        // Alarm at the wrap of the counter
        apb(1, `RPAC_OFF_PRESC, 0);
        apb(1, `RPAC_OFF_ALARM, 0);
        apb(1, `RPAC_OFF_COUNT, 32'hFFFFFFFF);
        apb(1, `RPAC_OFF_MASK, 32'h2);
        apb(1, `RPAC_OFF_STAT, 32'hF);
        n = 0;
        do begin @(negedge clk); n++; end while (alarm !== 1'b1 && n < 200);
        `CHK(n < 200, 1'b1)
        @(negedge clk); `CHK(alarm, 1'b0)
        `CHK(irq, 1'b1)
        @(posedge clk);
        apb(0, `RPAC_OFF_ALARM, 0); `CHK(rd, 32'h00000000)
        apb(0, `RPAC_OFF_COUNT, 0); `CHK(rd, 32'h00000000)
        apb(1, `RPAC_OFF_STAT, 32'h2);
        apb(0, `RPAC_OFF_STAT, 0); `CHK(rd[1], 1'b0)
        `CHK(irq, 1'b0)
        $display("Alarm done");
        // Every third tick, then every tick routed out
        apb(1, `RPAC_OFF_NTICK, 3);
        apb(1, `RPAC_OFF_CTRL, 32'h11);
        tick_gap(1, n); `CHK(n, 192)
        apb(1, `RPAC_OFF_XSEL, 1);
        tick_gap(2, n); `CHK(n, 64)
        $display("Cyclic requests done");
        // Frozen chain read as two words
        apb(1, `RPAC_OFF_CTRL, 0);
        apb(1, `RPAC_OFF_PRESC, 32'hABCDE);
        apb(1, `RPAC_OFF_COUNT, 32'h12345678);
        apb(0, `RPAC_OFF_LONG_LO, 0); `CHK(rd, {6'h38, 20'hABCDE, 6'h00})
        apb(0, `RPAC_OFF_LONG_HI, 0); `CHK(rd, 32'h12345678 >> 6)
        $display("Long timer done");
        // Oscillator control in power-down, main source
        pd <= 1'b1;
        apb(1, `RPAC_OFF_CTRL, 32'h03); @(negedge clk);
        `CHK({mosc, losc}, 2'b01)
        @(posedge clk);
        apb(1, `RPAC_OFF_CTRL, 32'h01); @(negedge clk);
        `CHK({mosc, losc}, 2'b11)
        @(posedge clk);
        apb(1, `RPAC_OFF_CTRL, 32'h00); @(negedge clk);
        `CHK({mosc, losc}, 2'b00)
        @(posedge clk);
        // Wake on the third tick of 64 clocks, plus two flops
        apb(1, `RPAC_OFF_XSEL, 0);
        apb(1, `RPAC_OFF_WDLY, 2);
        apb(1, `RPAC_OFF_PRESC, 0);
        apb(1, `RPAC_OFF_CTRL, 32'h0D);
        n = 0;
        do begin @(negedge clk); n++; end while (wake !== 1'b1 && n < 400);
        `CHK(n, 194)
        @(posedge clk);
        pd <= 1'b0;
        $display("Main source power-down done");
        // Low-power source found after a fresh reset
        do_reset(1'b1);
        apb(0, `RPAC_OFF_SRC, 0); `CHK(rd[0], 1'b1)
        pd <= 1'b1;
        apb(1, `RPAC_OFF_CTRL, 32'h09); @(negedge clk);
        `CHK({mosc, losc}, 2'b01)
        @(posedge clk);
        // One tick per slow edge, an edge every 8 clocks
        apb(1, `RPAC_OFF_PRESC, 0);
        apb(1, `RPAC_OFF_COUNT, 0);
        repeat (100) @(posedge clk);
        apb(0, `RPAC_OFF_COUNT, 0); `CHK(rd > 32'h9, 1'b1)
        pd <= 1'b0;
        $display("Low-power source done");
        report_and_stop();
    end
endmodule
`default_nettype wire
